// ==== rtl/ptce_ctrl.sv ====
/*
 * Tuning engine, done flag, calibration enable and divider reset control.
 * Assumes a synchronous single-cycle register port and a comparator input
 * from the oscillator saying whether it runs above its target.
 */
`timescale 1ns/10ps
`default_nettype none

// How it works
// R01: Three-bit settle setting, reset four, longer waits
// R02: Engine runs only when enable bit set
// R03: Tuning starts when PLL reset written zero
// R04: Engine trims oscillator until centred
// R05: Software changes tuning control under PLL reset
// R06: Read-only done flag set after run
// R07: Done also set when tuning skipped
// R08: Software leaves trim alone during tuning
// R09: Calibration runs while enable high, reset one
// R10: Clearing calibration enable resets clock dividers
// R11: Software clears enable before certain changes
// R12: Setting enable again reruns calibration
// R13: Calibration enable set before link enable
// R14: Link enable cleared before calibration enable
// R15: Software writes reset value to reserved
// R16: PLL reset set around PLL programming
// R17: Seven-bit read/write trim field
// R18: Done cleared under PLL reset when enabled
module ptce_ctrl
    import ptce_pkg::*;
#(
    parameter int SETTLE_BASE = PTCE_SETTLE_BASE_CYC
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire ptce_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire logic osc_fast,
    output logic [PTCE_TRIM_W-1:0] osc_trim,
    output logic tune_busy,
    output logic cal_run,
    output logic div_rst,
    output logic cal_restart
);

////////////////////////////////////////////////////////////////////////////
    logic rst_s1_r;
    logic rst_n_r;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

////////////////////////////////////////////////////////////////////////////
    logic [7:0] trim_r, trim_nxt;
    logic [7:0] prst_r, prst_nxt;
    logic [7:0] tctl_r, tctl_nxt;
    logic [7:0] cctl_r, cctl_nxt;
    logic [7:0] cset_r, cset_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic done_r, done_nxt;
    logic restart_r, restart_nxt;
    ptce_state_t st_r, st_nxt;
    logic [PTCE_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [PTCE_TRIM_W-1:0] step_r, step_nxt;
    logic wr_prst, pll_rel, eng_en;

    function automatic logic hit(input ptce_req_t q, input logic [7:0] a);
        return q.wr && (q.addr == a);
    endfunction

    assign wr_prst = hit(reg_req, PTCE_ADDR_PRST);
    assign pll_rel = wr_prst && !reg_req.wdata[PTCE_EN_BIT] && prst_r[PTCE_EN_BIT];
    assign eng_en = tctl_r[PTCE_EN_BIT];

    // Settle wait grows with setting: base << stl
    function automatic logic [PTCE_CNT_W-1:0] settle_cyc(input logic [PTCE_STL_W-1:0] s);
        return PTCE_CNT_W'(SETTLE_BASE) << s;
    endfunction

    always_comb begin
        trim_nxt = trim_r;
        prst_nxt = prst_r;
        tctl_nxt = tctl_r;
        cctl_nxt = cctl_r;
        cset_nxt = cset_r;
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        step_nxt = step_r;
        done_nxt = done_r;
        restart_nxt = 1'b0;
        if (hit(reg_req, PTCE_ADDR_TRIM)) begin
            trim_nxt = reg_req.wdata; // R17
        end
        if (wr_prst) begin
            prst_nxt = reg_req.wdata;
        end
        if (hit(reg_req, PTCE_ADDR_TCTL)) begin
            tctl_nxt = reg_req.wdata; // R01
        end
        if (hit(reg_req, PTCE_ADDR_CSET)) begin
            cset_nxt = reg_req.wdata;
        end
        if (hit(reg_req, PTCE_ADDR_CCTL)) begin
            cctl_nxt = reg_req.wdata;
            // Rising enable restarts calibration with new settings
            restart_nxt = reg_req.wdata[PTCE_EN_BIT] && !cctl_r[PTCE_EN_BIT]; // R12
        end
        if (prst_r[PTCE_EN_BIT] && eng_en) begin
            done_nxt = 1'b0; // R18
        end
        unique case (st_r)
            PTCE_IDLE: begin
                if (pll_rel) begin // R03
                    if (eng_en) begin // R02
                        st_nxt = PTCE_STEP;
                        done_nxt = 1'b0;
                        trim_nxt = {trim_r[7], 1'b1, {(PTCE_TRIM_W-1){1'b0}}};
                        step_nxt = {2'b01, {(PTCE_TRIM_W-2){1'b0}}};
                    end else begin
                        done_nxt = 1'b1; // R07
                    end
                end
            end
            PTCE_STEP: begin
                cnt_nxt = settle_cyc(tctl_r[PTCE_STL_LSB +: PTCE_STL_W]); // R01
                st_nxt = PTCE_SETTLE;
            end
            PTCE_SETTLE: begin
                if (cnt_r > PTCE_CNT_W'(1)) begin
                    cnt_nxt = cnt_r - PTCE_CNT_W'(1);
                end else begin
                    // Binary search: keep bit if not fast, then try next
                    if (osc_fast) begin // R04
                        trim_nxt[PTCE_TRIM_W-1:0] = (trim_r[PTCE_TRIM_W-1:0] & ~(step_r << 1))
                            | step_r;
                    end else begin
                        trim_nxt[PTCE_TRIM_W-1:0] = trim_r[PTCE_TRIM_W-1:0] | step_r;
                    end
                    if (step_r == '0) begin
                        st_nxt = PTCE_DONE;
                        if (osc_fast) begin
                            trim_nxt[0] = 1'b0;
                        end
                    end else begin
                        step_nxt = step_r >> 1;
                        st_nxt = PTCE_STEP;
                    end
                end
            end
            PTCE_DONE: begin
                done_nxt = 1'b1; // R06
                st_nxt = PTCE_IDLE;
            end
        endcase
        rdata_nxt = 8'h00;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                PTCE_ADDR_TRIM: rdata_nxt = trim_r;
                PTCE_ADDR_PRST: rdata_nxt = prst_r;
                PTCE_ADDR_TCTL: rdata_nxt = tctl_r;
                PTCE_ADDR_PROG: rdata_nxt = {7'h00, done_r};
                PTCE_ADDR_CCTL: rdata_nxt = cctl_r;
                PTCE_ADDR_CSET: rdata_nxt = cset_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            trim_r <= PTCE_RST_TRIM;
            prst_r <= PTCE_RST_PRST;
            tctl_r <= PTCE_RST_TCTL;
            cctl_r <= PTCE_RST_CCTL;
            cset_r <= PTCE_RST_CSET;
            rdata_r <= 8'h00;
            done_r <= 1'b0;
            restart_r <= 1'b0;
            st_r <= PTCE_IDLE;
            cnt_r <= '0;
            step_r <= '0;
        end else begin
            trim_r <= trim_nxt;
            prst_r <= prst_nxt;
            tctl_r <= tctl_nxt;
            cctl_r <= cctl_nxt;
            cset_r <= cset_nxt;
            rdata_r <= rdata_nxt;
            done_r <= done_nxt;
            restart_r <= restart_nxt;
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            step_r <= step_nxt;
        end
    end

////////////////////////////////////////////////////////////////////////////
    logic busy_r;
    logic cal_run_r;
    logic div_rst_r;

    always_ff @(posedge ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            busy_r <= 1'b0;
            cal_run_r <= PTCE_RST_CCTL[PTCE_EN_BIT];
            div_rst_r <= !PTCE_RST_CCTL[PTCE_EN_BIT];
        end else begin
            busy_r <= (st_nxt != PTCE_IDLE);
            cal_run_r <= cctl_nxt[PTCE_EN_BIT]; // R09
            div_rst_r <= !cctl_nxt[PTCE_EN_BIT]; // R10
        end
    end

    assign reg_rdata = rdata_r;
    assign osc_trim = trim_r[PTCE_TRIM_W-1:0];
    assign tune_busy = busy_r;
    assign cal_run = cal_run_r;
    assign div_rst = div_rst_r;
    assign cal_restart = restart_r;

////////////////////////////////////////////////////////////////////////////
    property p_skip_done;
        @(posedge ref_clk) disable iff (!rst_n_r)
        (pll_rel && !eng_en && st_r == PTCE_IDLE) |=> done_r;
    endproperty
    a_skip_done: assert property (p_skip_done) else $error("Skip did not set done"); // R07

    // First trim step, then busy seen on the port
    sequence s_start_seen;
        (st_r == PTCE_STEP) ##1 tune_busy;
    endsequence

    property p_start;
        @(posedge ref_clk) disable iff (!rst_n_r)
        (pll_rel && eng_en && st_r == PTCE_IDLE) |=> s_start_seen;
    endproperty
    a_start: assert property (p_start) else $error("Tuning did not start"); // R03

    property p_no_start;
        @(posedge ref_clk) disable iff (!rst_n_r)
        (st_r == PTCE_IDLE && !pll_rel) |=> st_r == PTCE_IDLE;
    endproperty
    a_no_start: assert property (p_no_start) else $error("Tuning started early"); // R03

    property p_clear;
        @(posedge ref_clk) disable iff (!rst_n_r)
        (prst_r[PTCE_EN_BIT] && eng_en && st_r == PTCE_IDLE) |=> !done_r;
    endproperty
    a_clear: assert property (p_clear) else $error("Done not cleared"); // R18

    property p_done;
        @(posedge ref_clk) disable iff (!rst_n_r)
        (st_r == PTCE_DONE) |=> done_r && !tune_busy;
    endproperty
    a_done: assert property (p_done) else $error("Done not raised"); // R06

    property p_settle;
        @(posedge ref_clk) disable iff (!rst_n_r)
        (st_r == PTCE_STEP) |=> cnt_r == settle_cyc(tctl_r[PTCE_STL_LSB +: PTCE_STL_W]);
    endproperty
    a_settle: assert property (p_settle) else $error("Settle count wrong"); // R01

    property p_cal;
        @(posedge ref_clk) disable iff (!rst_n_r)
        1'b1 |=> (cal_run == $past(cctl_nxt[PTCE_EN_BIT])) && (div_rst != cal_run);
    endproperty
    a_cal: assert property (p_cal) else $error("Calibration enable mismatch"); // R10

    property p_restart;
        @(posedge ref_clk) disable iff (!rst_n_r)
        cal_restart |-> cal_run && $past(cctl_r[PTCE_EN_BIT]) == 1'b0;
    endproperty
    a_restart: assert property (p_restart) else $error("Bad restart pulse"); // R12
endmodule

`default_nettype wire

// ==== rtl/ptce_pkg.sv ====
/*
 * Package for the PLL tuning and converter calibration enable control block.
 * Assumes an 8-bit register port with byte addresses as printed.
 */
package ptce_pkg;
    // Register addresses
    localparam logic [7:0] PTCE_ADDR_TRIM = 8'h59;
    localparam logic [7:0] PTCE_ADDR_PRST = 8'h5c;
    localparam logic [7:0] PTCE_ADDR_TCTL = 8'h5d;
    localparam logic [7:0] PTCE_ADDR_PROG = 8'h5e;
    localparam logic [7:0] PTCE_ADDR_CCTL = 8'h61;
    localparam logic [7:0] PTCE_ADDR_CSET = 8'h62;
    // Reset values
    localparam logic [7:0] PTCE_RST_TRIM = 8'h00;
    localparam logic [7:0] PTCE_RST_PRST = 8'h00;
    localparam logic [7:0] PTCE_RST_TCTL = 8'h40;
    localparam logic [7:0] PTCE_RST_CCTL = 8'h01;
    localparam logic [7:0] PTCE_RST_CSET = 8'h01;
    // Field positions
    localparam int PTCE_EN_BIT = 0;
    localparam int PTCE_STL_LSB = 4;
    localparam int PTCE_STL_W = 3;
    localparam int PTCE_TRIM_W = 7;
    // Settle wait is base cycles shifted by the setting
    localparam int PTCE_SETTLE_BASE_NS = 80;
    localparam int PTCE_CLK_NS = 10;
    localparam int PTCE_SETTLE_BASE_CYC = (PTCE_SETTLE_BASE_NS + PTCE_CLK_NS - 1) / PTCE_CLK_NS;
    localparam int PTCE_CNT_W = 16;

    typedef enum logic [1:0] {
        PTCE_IDLE,
        PTCE_STEP,
        PTCE_SETTLE,
        PTCE_DONE
    } ptce_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ptce_req_t;
endpackage

// ==== testbench/ptce_ctrl_test.sv ====
/*
 * Self-checking bench for the tuning engine and calibration enable control.
 * Assumes ptce_pkg and ptce_ctrl compiled first; the bench drives every port.
 */
`timescale 1ns/10ps
`default_nettype none
module ptce_ctrl_test
    import ptce_pkg::*;
;
    localparam logic [6:0] TARGET = 7'h2b;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    ptce_req_t req = '0;
    logic osc_fast = 1'b0;
    logic [7:0] reg_rdata;
    logic [PTCE_TRIM_W-1:0] osc_trim;
    logic tune_busy, cal_run, div_rst, cal_restart;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    int pulses = 0;
    int d1, d3, p0;

    always #5 ref_clk = ~ref_clk;

    ptce_ctrl #(.SETTLE_BASE(1)) i_ptce_ctrl (.ref_clk(ref_clk), .nrst(nrst), .reg_req(req),
        .reg_rdata(reg_rdata), .osc_fast(osc_fast), .osc_trim(osc_trim),
        .tune_busy(tune_busy), .cal_run(cal_run), .div_rst(div_rst),
        .cal_restart(cal_restart));

    ////////////////////////////////////////////////////////////////////////////////
    // Oscillator stand-in, fast once trim passes the target
    always @(negedge ref_clk) osc_fast <= (osc_trim > TARGET);

    // Restart pulses counted here so a short pulse is never missed
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cal_restart === 1'b1) pulses <= pulses + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge ref_clk);
        req = '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(negedge ref_clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge ref_clk);
        req = '0;
        chk(name, exp, reg_rdata);
    endtask

    // One enabled run; dur counts busy cycles
    task automatic tune(input logic [2:0] stl, output int dur);
        wr(PTCE_ADDR_PRST, 8'h01);
        wr(PTCE_ADDR_TCTL, {1'b0, stl, 4'h1});
        rd(PTCE_ADDR_PROG, 8'h00, "done under pll reset");
        chk("busy before release", 8'h00, {7'h0, tune_busy});
        wr(PTCE_ADDR_PRST, 8'h00);
        dur = 0;
        repeat (10) if (tune_busy !== 1'b1) @(negedge ref_clk);
        while (tune_busy === 1'b1 && dur < 2000) begin
            @(negedge ref_clk);
            dur++;
        end
        repeat (2) @(negedge ref_clk);
        chk("trim port", {1'b0, TARGET}, {1'b0, osc_trim});
        rd(PTCE_ADDR_TRIM, {1'b0, TARGET}, "trim reg");
        rd(PTCE_ADDR_PROG, 8'h01, "done after run");
    endtask

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (3) @(negedge ref_clk);
        rd(PTCE_ADDR_TCTL, 8'h40, "tune control reset");
        rd(PTCE_ADDR_CCTL, 8'h01, "cal control reset");
        rd(PTCE_ADDR_CSET, 8'h01, "cal setup reset");
        rd(PTCE_ADDR_PROG, 8'h00, "progress reset");
        rd(8'h70, 8'h00, "unmapped read");
        chk("run and divider reset", 8'h02, {6'h0, cal_run, div_rst});
        wr(PTCE_ADDR_PROG, 8'hff);
        rd(PTCE_ADDR_PROG, 8'h00, "progress read only");
        $display("test registers done");

        wr(PTCE_ADDR_PRST, 8'h01);
        wr(PTCE_ADDR_TCTL, 8'h40);
        wr(PTCE_ADDR_PRST, 8'h00);
        repeat (4) begin
            @(negedge ref_clk);
            chk("busy with engine off", 8'h00, {7'h0, tune_busy});
        end
        rd(PTCE_ADDR_PROG, 8'h01, "done when skipped");
        rd(PTCE_ADDR_TRIM, 8'h00, "trim untouched");
        $display("test skipped tuning done");

        tune(3'd1, d1);
        tune(3'd3, d3);
        chk("short settle run", 8'h01, {7'h0, d1 >= 14});
        chk("settle grows", 8'h01, {7'h0, d3 - d1 >= 35});
        // Trim is only touched while done reads one, before PLL reset clears it
        rd(PTCE_ADDR_PROG, 8'h01, "done before trim write");
        wr(PTCE_ADDR_TRIM, 8'h55);
        rd(PTCE_ADDR_TRIM, 8'h55, "trim rw");
        chk("trim port rw", 8'h55, {1'b0, osc_trim});
        wr(PTCE_ADDR_PRST, 8'h01);
        $display("test tuning done");

        wr(PTCE_ADDR_CCTL, 8'h00);
        chk("cal held", 8'h01, {6'h0, cal_run, div_rst});
        rd(PTCE_ADDR_CCTL, 8'h00, "cal control cleared");
        wr(PTCE_ADDR_CSET, 8'h03);
        rd(PTCE_ADDR_CSET, 8'h03, "cal setup rw");
        p0 = pulses;
        wr(PTCE_ADDR_CCTL, 8'h01);
        repeat (3) @(negedge ref_clk);
        chk("restart pulses", 8'h01, 8'(pulses - p0));
        chk("cal running", 8'h02, {6'h0, cal_run, div_rst});
        p0 = pulses;
        wr(PTCE_ADDR_CCTL, 8'h01);
        repeat (3) @(negedge ref_clk);
        chk("no restart on rewrite", 8'h00, 8'(pulses - p0));
        $display("test calibration enable done");
        end_sim();
    end
endmodule
`default_nettype wire
